/* rtl/nrt_consts.svh */
// Register offsets, field positions and reset values for the requester ID translator
`ifndef NRT_CONSTS_SVH
`define NRT_CONSTS_SVH

`define NRT_TBL_NEAR_BASE   12'h000
`define NRT_TBL_FAR_BASE    12'h040
`define NRT_TBL_REGION_END  12'h080
`define NRT_STATUS_OFS      12'h080
`define NRT_CLEAR_OFS       12'h084
`define NRT_ENABLE_OFS      12'h088
`define NRT_NEAR_BDF_OFS    12'h08c
`define NRT_FAR_BDF_OFS     12'h090

`define NRT_ENT_BUS_HI      31
`define NRT_ENT_BUS_LO      24
`define NRT_ENT_DEV_HI      23
`define NRT_ENT_DEV_LO      19
`define NRT_ENT_FUN_HI      18
`define NRT_ENT_FUN_LO      16
`define NRT_ENT_VALID       0
`define NRT_ENT_KEEP_MASK   32'hffff_0001

`define NRT_ENTRIES         16
`define NRT_LAST_ENTRY      8'h0f

`define NRT_ST_NEAR_UR      0
`define NRT_ST_FAR_UR       1
`define NRT_ST_NEAR_CPL     2
`define NRT_ST_FAR_CPL      3
`define NRT_ST_W            4

`define NRT_ENTRY_RST       32'h0000_0000
`define NRT_BDF_RST         16'h0000
`define NRT_STATUS_RST      4'h0
`define NRT_ENABLE_RST      4'h0

`define NRT_RESP_OKAY       2'h0
`define NRT_RESP_SLVERR     2'h2

`endif

/* rtl/nrt_pkg.sv */
// Types shared by the requester ID translator
package nrt_pkg;

  typedef enum logic [2:0] {
    NRT_REQ_POSTED,
    NRT_REQ_NONPOSTED,
    NRT_COMPLETION,
    NRT_MESSAGE,
    NRT_CONFIG
  } nrt_kind_t;

  // Side 0 is the near_side_endpoint, side 1 the far_side_endpoint
  typedef struct packed {
    logic        side;
    nrt_kind_t   kind;
    logic [15:0] req_id;
    logic [15:0] cpl_id;
    logic [7:0]  tag;
    logic [63:0] addr;
  } nrt_hdr_t;

  typedef struct packed {
    logic       hit;
    logic [3:0] idx;
  } nrt_match_t;

endpackage

/* rtl/nrt_id_translator.sv */
// Requester and completer ID translation for an isolating_bridge, with AXI4-Lite registers
`timescale 1ns/1ps
`include "nrt_consts.svh"

module nrt_id_translator (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [11:0]      s_axi_awaddr,
  input  wire logic [2:0]       s_axi_awprot,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0]      s_axi_araddr,
  input  wire logic [2:0]       s_axi_arprot,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Received packet headers from either endpoint
  input  wire nrt_pkg::nrt_hdr_t rx_hdr,
  input  wire logic             rx_valid,
  output logic                  rx_ready,
  // Forwarded packet headers towards the opposite endpoint
  output nrt_pkg::nrt_hdr_t     tx_hdr,
  output logic                  tx_valid,
  input  wire logic             tx_ready,
  // Interrupt
  output logic                  irq
);

  // Tables, side 0 near, side 1 far
  logic [31:0]             map_tbl [0:1][0:`NRT_ENTRIES-1];
  logic [15:0]             ep_bdf  [0:1];
  logic [`NRT_ST_W-1:0]    status;
  logic [`NRT_ST_W-1:0]    enable;
  logic [`NRT_ST_W-1:0]    ev_set;
  logic [`NRT_ST_W-1:0]    sw_clear;

  // Bus slave holding registers
  logic                    aw_hold;
  logic [11:0]             aw_addr;
  logic                    w_hold;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    wr_fire;

  // Packet path
  logic                    rx_take;
  logic                    rx_side;
  logic                    opp_side;
  nrt_pkg::nrt_match_t     req_match;
  logic [7:0]              cpl_index;
  logic [31:0]             cpl_entry;
  logic                    fwd;
  nrt_pkg::nrt_hdr_t       next_tx_hdr;

  // Identity held in an entry, as a requester ID
  function automatic logic [15:0] entry_bdf(input logic [31:0] ent);
    entry_bdf = {ent[`NRT_ENT_BUS_HI:`NRT_ENT_BUS_LO],
                 ent[`NRT_ENT_DEV_HI:`NRT_ENT_DEV_LO],
                 ent[`NRT_ENT_FUN_HI:`NRT_ENT_FUN_LO]};
  endfunction

  // Byte-lane merge for a register write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    lane_merge = r;
  endfunction

  // Search runs high to low so the lowest matching valid entry is the last to land
  function automatic nrt_pkg::nrt_match_t lookup(input logic sd, input logic [15:0] rid);
    nrt_pkg::nrt_match_t m;
    m.hit = 1'b0;
    m.idx = 4'h0;
    for (int i = `NRT_ENTRIES - 1; i >= 0; i--) begin
      if (map_tbl[sd][i][`NRT_ENT_VALID] && (entry_bdf(map_tbl[sd][i]) == rid)) begin
        m.hit = 1'b1;
        m.idx = 4'(i);
      end
    end
    lookup = m;
  endfunction

  // ---------------------------------------------------------------- bus slave

  assign s_axi_awready = !aw_hold;
  assign s_axi_wready  = !w_hold;
  assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_addr <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold <= 1'b0;
    end
  end

  // Write response and register updates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `NRT_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr < `NRT_TBL_REGION_END || aw_addr == `NRT_CLEAR_OFS || aw_addr == `NRT_ENABLE_OFS ||
          aw_addr == `NRT_NEAR_BDF_OFS || aw_addr == `NRT_FAR_BDF_OFS) begin
        s_axi_bresp <= `NRT_RESP_OKAY;
      end else begin
        s_axi_bresp <= `NRT_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Tables are filled by software during initialisation; reset leaves every entry invalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < `NRT_ENTRIES; i++) begin
          map_tbl[s][i] <= `NRT_ENTRY_RST;
        end
      end
    end else if (wr_fire && aw_addr < `NRT_TBL_REGION_END) begin
      // Reserved bits are not stored, so they read back as zero
      map_tbl[aw_addr[6]][aw_addr[5:2]] <=
        lane_merge(map_tbl[aw_addr[6]][aw_addr[5:2]], w_data, w_strb) & `NRT_ENT_KEEP_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ep_bdf[0] <= `NRT_BDF_RST;
      ep_bdf[1] <= `NRT_BDF_RST;
    end else if (wr_fire) begin
      if (aw_addr == `NRT_NEAR_BDF_OFS) begin
        ep_bdf[0] <= 16'(lane_merge({16'h0000, ep_bdf[0]}, w_data, w_strb));
      end else if (aw_addr == `NRT_FAR_BDF_OFS) begin
        ep_bdf[1] <= 16'(lane_merge({16'h0000, ep_bdf[1]}, w_data, w_strb));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable <= `NRT_ENABLE_RST;
    end else if (wr_fire && aw_addr == `NRT_ENABLE_OFS && w_strb[0]) begin
      enable <= w_data[`NRT_ST_W-1:0];
    end
  end

  assign sw_clear = (wr_fire && aw_addr == `NRT_CLEAR_OFS && w_strb[0]) ? w_data[`NRT_ST_W-1:0]
                                                                        : `NRT_STATUS_RST;

  // An event in the same cycle as its clear survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= `NRT_STATUS_RST;
    end else begin
      status <= (status & ~sw_clear) | ev_set;
    end
  end

  assign irq = |(status & enable);

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `NRT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `NRT_RESP_OKAY;
      if (s_axi_araddr < `NRT_TBL_REGION_END) begin
        s_axi_rdata <= map_tbl[s_axi_araddr[6]][s_axi_araddr[5:2]];
      end else if (s_axi_araddr == `NRT_STATUS_OFS) begin
        s_axi_rdata <= {28'h000_0000, status};
      end else if (s_axi_araddr == `NRT_CLEAR_OFS) begin
        s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_araddr == `NRT_ENABLE_OFS) begin
        s_axi_rdata <= {28'h000_0000, enable};
      end else if (s_axi_araddr == `NRT_NEAR_BDF_OFS) begin
        s_axi_rdata <= {16'h0000, ep_bdf[0]};
      end else if (s_axi_araddr == `NRT_FAR_BDF_OFS) begin
        s_axi_rdata <= {16'h0000, ep_bdf[1]};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `NRT_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------- packet path

  // One output stage; a stalled output holds the input back
  assign rx_ready  = !tx_valid || tx_ready;
  assign rx_take   = rx_valid && rx_ready;
  assign rx_side   = rx_hdr.side;
  assign opp_side  = !rx_hdr.side;
  assign req_match = lookup(rx_side, rx_hdr.req_id);
  assign cpl_index = rx_hdr.req_id[7:0];
  // Index is at most eight bits but the table stops at fifteen
  assign cpl_entry = (cpl_index > `NRT_LAST_ENTRY) ? `NRT_ENTRY_RST
                                                   : map_tbl[opp_side][cpl_index[3:0]];

  always_comb begin
    fwd         = 1'b0;
    ev_set      = `NRT_STATUS_RST;
    next_tx_hdr = rx_hdr;
    next_tx_hdr.side = opp_side;
    if (rx_take) begin
      case (rx_hdr.kind)
        nrt_pkg::NRT_REQ_POSTED, nrt_pkg::NRT_REQ_NONPOSTED: begin
          if (req_match.hit) begin
            fwd = 1'b1;
            next_tx_hdr.req_id = {ep_bdf[opp_side][15:8], 4'h0, req_match.idx};
          end else if (rx_side) begin
            ev_set[`NRT_ST_FAR_UR] = 1'b1;
          end else begin
            ev_set[`NRT_ST_NEAR_UR] = 1'b1;
          end
        end
        nrt_pkg::NRT_COMPLETION: begin
          if (cpl_index <= `NRT_LAST_ENTRY && cpl_entry[`NRT_ENT_VALID]) begin
            fwd = 1'b1;
            next_tx_hdr.req_id = entry_bdf(cpl_entry);
            next_tx_hdr.cpl_id = ep_bdf[opp_side];
          end else if (rx_side) begin
            ev_set[`NRT_ST_FAR_CPL] = 1'b1;
          end else begin
            ev_set[`NRT_ST_NEAR_CPL] = 1'b1;
          end
        end
        // Messages vanish without a trace; configuration belongs to the receiving endpoint
        nrt_pkg::NRT_MESSAGE: begin
          fwd = 1'b0;
        end
        default: begin
          fwd = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_valid <= 1'b0;
    end else if (rx_ready) begin
      tx_valid <= fwd;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hdr <= '0;
    end else if (rx_take && fwd) begin
      tx_hdr <= next_tx_hdr;
    end
  end

endmodule // nrt_id_translator

/* tb/nrt_id_translator_chk.sv */
// Port assertions for the requester ID translator
`timescale 1ns/1ps
module nrt_id_translator_chk (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Packet stream
  input wire nrt_pkg::nrt_hdr_t rx_hdr,
  input wire logic              rx_valid,
  input wire logic              rx_ready,
  input wire nrt_pkg::nrt_hdr_t tx_hdr,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  // Register answers
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take; rx_valid && rx_ready; endsequence
  sequence s_req; s_take ##0 (rx_hdr.kind inside {nrt_pkg::NRT_REQ_POSTED, nrt_pkg::NRT_REQ_NONPOSTED}); endsequence
  sequence s_cpl; s_take ##0 (rx_hdr.kind == nrt_pkg::NRT_COMPLETION); endsequence
  property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_hdr); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx header moved while stalled");
  property p_stall; tx_valid && !tx_ready |-> !rx_ready; endproperty
  a_stall: assert property (p_stall) else $error("rx taken while tx stalled");
  property p_msg; s_take ##0 (rx_hdr.kind == nrt_pkg::NRT_MESSAGE) |=> !tx_valid; endproperty
  a_msg: assert property (p_msg) else $error("message forwarded");
  property p_req_id; s_req |=> !tx_valid || (tx_hdr.req_id[7:4] == 4'h0 && tx_hdr.kind == $past(rx_hdr.kind)); endproperty
  a_req_id: assert property (p_req_id) else $error("bad forwarded request id");
  property p_req_side; s_req |=> !tx_valid || tx_hdr.side != $past(rx_hdr.side); endproperty
  a_req_side: assert property (p_req_side) else $error("request sent to wrong side");
  property p_cpl_side; s_cpl |=> !tx_valid || (tx_hdr.side != $past(rx_hdr.side) && tx_hdr.tag == $past(rx_hdr.tag)); endproperty
  a_cpl_side: assert property (p_cpl_side) else $error("completion sent wrongly");
  property p_cpl_range; s_cpl ##0 (rx_hdr.req_id[7:0] > 8'h0f) |=> !tx_valid; endproperty
  a_cpl_range: assert property (p_cpl_range) else $error("out of range completion forwarded");
  property p_keep; s_req |=> !tx_valid || tx_hdr.addr == $past(rx_hdr.addr); endproperty
  a_keep: assert property (p_keep) else $error("request address altered");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped early");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped early");
endmodule // nrt_id_translator_chk

/* tb/nrt_far_model.sv */
// Far side sink that stalls at random and records what crosses
`timescale 1ns/1ps
module nrt_far_model #(parameter int SEED = 311) (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // Forwarded stream
  input wire nrt_pkg::nrt_hdr_t tx_hdr,
  input wire logic              tx_valid,
  output logic                  tx_ready,
  // Capture
  output nrt_pkg::nrt_hdr_t     got_hdr,
  output int unsigned           got_n
);
  int seed = SEED;
  // Stalls make the translator hold its output
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_ready <= 1'b0;
      got_n <= 0;
    end else begin
      if (tx_valid && tx_ready) begin
        got_hdr <= tx_hdr;
        got_n <= got_n + 1;
      end
      tx_ready <= ($random(seed) & 3) != 0;
    end
  end
endmodule // nrt_far_model

/* tb/nrt_id_translator_tb.sv */
// Self-checking bench for the requester ID translator
`timescale 1ns/1ps
`include "nrt_consts.svh"
module nrt_id_translator_tb;
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [11:0]       awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, rx_valid = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, rx_ready, tx_valid, tx_ready, irq;
  logic [1:0]        bresp, rresp;
  nrt_pkg::nrt_hdr_t rx_hdr = '0, tx_hdr, got_hdr, h;
  int unsigned       got_n;
  int                failures = 0, cmp_count = 0, cyc = 0, seed = 5479;
  always #2.5 aclk = ~aclk;
  nrt_id_translator uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx_hdr(rx_hdr), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_hdr(tx_hdr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .irq(irq));
  nrt_far_model far (.aclk(aclk), .aresetn(aresetn), .tx_hdr(tx_hdr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .got_hdr(got_hdr), .got_n(got_n));
  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Address and data are offered together; each is released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    // Response ready comes late at random so a pending response must hold
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (!bready && ($random(seed) & 1)) bready <= 1'b1;
    end while (!(bvalid && bready) && ++n < 50);
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (!rready && ($random(seed) & 1)) rready <= 1'b1;
    end while (!(rvalid && rready) && ++n < 50);
    rready <= 1'b0;
    chk({rresp, rdata}, {er, ed});
  endtask
  task automatic pkt(input nrt_pkg::nrt_hdr_t p, input logic fwd, input nrt_pkg::nrt_hdr_t e);
    int n;
    int unsigned c0;
    n = 0;
    c0 = got_n;
    rx_hdr <= p;
    rx_valid <= 1'b1;
    do @(posedge aclk); while (!rx_ready && ++n < 50);
    rx_valid <= 1'b0;
    @(posedge aclk);
    chk(tx_valid, fwd);
    n = 0;
    if (fwd) begin
      do @(posedge aclk); while (got_n == c0 && ++n < 50);
      chk(got_hdr, e);
    end
  endtask
  function automatic nrt_pkg::nrt_hdr_t mk(logic s, nrt_pkg::nrt_kind_t k, logic [15:0] rid);
    mk = '0;
    mk.side = s;
    mk.kind = k;
    mk.req_id = rid;
    mk.cpl_id = 16'($random(seed));
    mk.tag = 8'($random(seed));
    mk.addr = {$random(seed), $random(seed)};
  endfunction
  function automatic nrt_pkg::nrt_hdr_t fw(nrt_pkg::nrt_hdr_t p, logic [15:0] rid, logic [15:0] cid);
    fw = p;
    fw.side = ~p.side;
    fw.req_id = rid;
    fw.cpl_id = cid;
  endfunction
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`NRT_TBL_FAR_BASE + 12'h03c, `NRT_ENTRY_RST, `NRT_RESP_OKAY);
    rd(`NRT_STATUS_OFS, 32'h0, `NRT_RESP_OKAY);
    wr(`NRT_NEAR_BDF_OFS, 32'h0500, `NRT_RESP_OKAY);
    wr(`NRT_FAR_BDF_OFS, 32'h0610, `NRT_RESP_OKAY);
    wr(`NRT_TBL_NEAR_BASE, 32'h0108_fffe, `NRT_RESP_OKAY);
    wr(`NRT_TBL_NEAR_BASE + 12'h008, 32'h0108_ffff, `NRT_RESP_OKAY);
    wr(`NRT_TBL_NEAR_BASE + 12'h014, 32'h0108_0001, `NRT_RESP_OKAY);
    wr(`NRT_TBL_FAR_BASE + 12'h03c, 32'h0600_0001, `NRT_RESP_OKAY);
    rd(`NRT_TBL_NEAR_BASE + 12'h008, 32'h0108_0001, `NRT_RESP_OKAY);
    rd(12'h0fc, 32'h0, `NRT_RESP_SLVERR);
    wr(12'h0fc, 32'h1, `NRT_RESP_SLVERR);
    wr(`NRT_STATUS_OFS, 32'hf, `NRT_RESP_SLVERR);
    wr(`NRT_ENABLE_OFS, 32'hf, `NRT_RESP_OKAY);
    // Lowest valid match is entry 2: entry 0 holds the same identity but is invalid
    for (int k = 0; k < 8; k++) begin
      h = mk(1'b0, k[0] ? nrt_pkg::NRT_REQ_NONPOSTED : nrt_pkg::NRT_REQ_POSTED, 16'h0108);
      pkt(h, 1'b1, fw(h, 16'h0602, h.cpl_id));
    end
    h = mk(1'b1, nrt_pkg::NRT_REQ_POSTED, 16'h0600);
    pkt(h, 1'b1, fw(h, 16'h050f, h.cpl_id));
    h = mk(1'b1, nrt_pkg::NRT_COMPLETION, 16'h0602);
    pkt(h, 1'b1, fw(h, 16'h0108, 16'h0500));
    h = mk(1'b0, nrt_pkg::NRT_COMPLETION, 16'h050f);
    pkt(h, 1'b1, fw(h, 16'h0600, 16'h0610));
    pkt(mk(1'b1, nrt_pkg::NRT_COMPLETION, 16'h0600), 1'b0, h);
    pkt(mk(1'b1, nrt_pkg::NRT_COMPLETION, 16'h063f), 1'b0, h);
    rd(`NRT_STATUS_OFS, 32'h8, `NRT_RESP_OKAY);
    chk(irq, 1'b1);
    wr(`NRT_CLEAR_OFS, 32'hf, `NRT_RESP_OKAY);
    pkt(mk(1'b0, nrt_pkg::NRT_REQ_POSTED, {1'b1, 15'($random(seed))}), 1'b0, h);
    rd(`NRT_STATUS_OFS, 32'h1, `NRT_RESP_OKAY);
    wr(`NRT_CLEAR_OFS, 32'hf, `NRT_RESP_OKAY);
    rd(`NRT_STATUS_OFS, 32'h0, `NRT_RESP_OKAY);
    chk(irq, 1'b0);
    wr(`NRT_ENABLE_OFS, 32'h0, `NRT_RESP_OKAY);
    pkt(mk(1'b1, nrt_pkg::NRT_REQ_NONPOSTED, 16'h0601), 1'b0, h);
    rd(`NRT_STATUS_OFS, 32'h2, `NRT_RESP_OKAY);
    chk(irq, 1'b0);
    wr(`NRT_ENABLE_OFS, 32'h2, `NRT_RESP_OKAY);
    chk(irq, 1'b1);
    wr(`NRT_CLEAR_OFS, 32'hf, `NRT_RESP_OKAY);
    pkt(mk(1'b0, nrt_pkg::NRT_MESSAGE, 16'h0108), 1'b0, h);
    pkt(mk(1'b1, nrt_pkg::NRT_MESSAGE, 16'h0600), 1'b0, h);
    rd(`NRT_STATUS_OFS, 32'h0, `NRT_RESP_OKAY);
    end_sim();
  end
  // A hang counts as a mismatch
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
endmodule // nrt_id_translator_tb
bind nrt_id_translator nrt_id_translator_chk u_chk (.aclk(aclk), .aresetn(aresetn), .rx_hdr(rx_hdr),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_hdr(tx_hdr), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
